/* File: hw/can_filter_defines.svh */
// offsets, field positions and reset values of the acceptance filter
// assumes a 32-bit filter element word read from message ram
`ifndef CAN_FILTER_DEFINES_SVH
`define CAN_FILTER_DEFINES_SVH

`define CF_REG_CTRL      8'h00
`define CF_REG_STD_LIST  8'h04
`define CF_REG_EXT_LIST  8'h08
`define CF_REG_EXT_MASK  8'h0c
`define CF_REG_RXBUF     8'h10
`define CF_REG_PRIO_FLAG 8'h14
`define CF_REG_PRIO_STAT 8'h18
`define CF_REG_RESULT    8'h1c

`define CF_CTRL_STAMP    0
`define CF_CTRL_IRQEN    1
`define CF_MASK_RESET    29'h1fffffff

`define CF_TYPE          31:30
`define CF_STD_CFG       29:27
`define CF_STD_ID1       26:16
`define CF_STD_SYNC      15
`define CF_STD_ID2       10:0
`define CF_EXT_CFG       31:29
`define CF_EXT_SYNC      29
`define CF_EXT_ID        28:0
`define CF_BUF_SEL       10:9
`define CF_BUF_FE        8:6
`define CF_BUF_OFS       5:0

`define CF_STD_MAX       128
`define CF_EXT_MAX       64

`endif

/* File: hw/can_filter_pkg.sv */
// types shared by the acceptance filter and its users
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package can_filter_pkg;

  typedef enum logic [2:0] {
    DEST_NONE   = 3'h0,
    DEST_FIFO0  = 3'h1,
    DEST_FIFO1  = 3'h2,
    DEST_REJECT = 3'h3,
    DEST_RXBUF  = 3'h4,
    DEST_DBG_A  = 3'h5,
    DEST_DBG_B  = 3'h6,
    DEST_DBG_C  = 3'h7
  } dest_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ADDR0 = 3'h1,
    S_DATA0 = 3'h2,
    S_ADDR1 = 3'h3,
    S_DATA1 = 3'h4,
    S_DONE  = 3'h5
  } state_t;

  typedef struct packed {
    logic        matched;
    dest_t       dest;
    logic        prio_match;
    logic        ext;
    logic [6:0]  index;
    logic [15:0] buf_addr;
  } result_t;

  typedef struct packed {
    logic        valid;
    logic        xtd;
    logic [28:0] id;
  } frame_t;

endpackage
`default_nettype wire

/* File: hw/can_rx_acceptance_filter.sv */
// acceptance filter: walks the filter lists for each received frame
// assumes a synchronous message ram with data one cycle after ram_rd
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "can_filter_defines.svh"

module can_rx_acceptance_filter
  import can_filter_pkg::*;
#(
  parameter int STD_MAX = `CF_STD_MAX,
  parameter int EXT_MAX = `CF_EXT_MAX
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire frame_t      frame,
  output logic             busy,
  output logic             ram_rd,
  output logic      [15:0] ram_addr,
  input  wire logic [31:0] ram_rdata,
  output logic             result_valid,
  output result_t          result,
  output logic             sync_rx,
  output logic      [2:0]  filter_event_pulses,
  output logic             prio_irq
);

  // the index and the list counters are sized for these limits only
  if (STD_MAX < 1 || STD_MAX > 128 ||
      EXT_MAX < 1 || EXT_MAX > 64) begin : bad_limits
    $error("filter list limits out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  logic        use_timestamp_unit;
  logic        irq_enable;
  logic [15:0] std_list_start_addr;
  logic [7:0]  std_count;
  logic [15:0] ext_list_start_addr;
  logic [7:0]  ext_count;
  logic [28:0] global_ext_id_mask;
  logic [15:0] rx_buffer_start_addr;
  logic        high_priority_match_flag;
  logic [9:0]  priority_match_status;

  state_t      state;
  logic        xtd_q;
  logic [28:0] id_q;
  logic [6:0]  idx_q;
  logic [31:0] word0_q;

  // register decode
  wire wr_ctrl = reg_wr && reg_addr == `CF_REG_CTRL;
  wire wr_std  = reg_wr && reg_addr == `CF_REG_STD_LIST;
  wire wr_ext  = reg_wr && reg_addr == `CF_REG_EXT_LIST;
  wire wr_mask = reg_wr && reg_addr == `CF_REG_EXT_MASK;
  wire wr_rxb  = reg_wr && reg_addr == `CF_REG_RXBUF;
  wire clr_pri = reg_wr && reg_addr == `CF_REG_PRIO_FLAG && reg_wdata[0];

  ////////////////////////////////////////////////////////////////////
  // element decode, valid while a data state holds the last word
  wire         eval  = (state == S_DATA0 && !xtd_q) || state == S_DATA1;
  wire  [2:0]  cfg   = xtd_q ? word0_q[`CF_EXT_CFG]
                             : ram_rdata[`CF_STD_CFG];
  wire  [1:0]  ftype = ram_rdata[`CF_TYPE];
  wire         sbit  = xtd_q ? ram_rdata[`CF_EXT_SYNC]
                             : ram_rdata[`CF_STD_SYNC];
  wire  [28:0] id1   = xtd_q ? word0_q[`CF_EXT_ID]
                             : {18'h0, ram_rdata[`CF_STD_ID1]};
  wire  [28:0] id2   = xtd_q ? ram_rdata[`CF_EXT_ID]
                             : {18'h0, ram_rdata[`CF_STD_ID2]};
  wire  [28:0] rid   = xtd_q ? (id_q & global_ext_id_mask) : id_q;
  wire  [10:0] sel2  = id2[10:0];

  // filter type comparisons
  wire in_range  = rid >= id1 && rid <= id2;
  wire dual_hit  = rid == id1 || rid == id2;
  wire class_hit = ((rid ^ id1) & id2) == 29'h0;
  wire raw_range = id_q >= id1 && id_q <= id2;
  wire exact_hit = rid == id1;

  logic type_hit;
  // type 11 means range without mask on the extended list only
  always_comb begin
    case (ftype)
      2'h0:    type_hit = in_range;
      2'h1:    type_hit = dual_hit;
      2'h2:    type_hit = class_hit;
      default: type_hit = xtd_q && raw_range;
    endcase
  end

  // a disabled element never matches and the walk moves on
  wire std_off = !xtd_q && ftype == 2'h3 && cfg != 3'h7;
  wire enabled = cfg != 3'h0 && !std_off;
  wire hit     = enabled && (cfg == 3'h7 ? exact_hit : type_hit);
  wire prio    = cfg == 3'h4 || cfg == 3'h5 || cfg == 3'h6;

  // end of list; a count above the limit is clipped to the limit
  wire [7:0] cnt   = xtd_q ? ext_count : std_count;
  wire [7:0] lim   = xtd_q ? 8'(EXT_MAX) : 8'(STD_MAX);
  wire [7:0] cnt_e = cnt > lim ? lim : cnt;
  wire       last  = ({1'b0, idx_q} + 8'h01) >= cnt_e;

  // element addresses
  wire [6:0]  nidx   = idx_q + 7'h01;
  wire [15:0] std_ad = std_list_start_addr + {9'h0, nidx};
  wire [15:0] ext_ad = ext_list_start_addr + {8'h0, nidx, 1'b0};
  wire [7:0]  fcnt   = frame.xtd ? ext_count : std_count;

  dest_t dest;
  // destination from the configuration code
  always_comb begin
    case (cfg)
      3'h1, 3'h5: dest = DEST_FIFO0;
      3'h2, 3'h6: dest = DEST_FIFO1;
      3'h3:       dest = DEST_REJECT;
      3'h7: begin
        case (sel2[10:9])
          2'h0:    dest = DEST_RXBUF;
          2'h1:    dest = DEST_DBG_A;
          2'h2:    dest = DEST_DBG_B;
          default: dest = DEST_DBG_C;
        endcase
      end
      default:    dest = DEST_NONE;
    endcase
  end

  wire [15:0] buf_ad = rx_buffer_start_addr
                     + {10'h0, sel2[`CF_BUF_OFS]};
  wire        take   = eval && hit;
  wire        pset   = take && prio;

  ////////////////////////////////////////////////////////////////////
  // search state machine
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state  <= S_IDLE;
      ram_rd <= 1'b0;
    end else begin
      ram_rd <= 1'b0;
      case (state)
        S_IDLE: begin
          if (frame.valid) begin
            state <= fcnt == 8'h00 ? S_DONE : S_ADDR0;
            ram_rd <= fcnt != 8'h00;
          end
        end
        S_ADDR0: state <= S_DATA0;
        S_DATA0: begin
          if (xtd_q) begin
            state  <= S_ADDR1;
            ram_rd <= 1'b1;
          end else if (hit || last) begin
            state <= S_DONE;
          end else begin
            state  <= S_ADDR0;
            ram_rd <= 1'b1;
          end
        end
        S_ADDR1: state <= S_DATA1;
        S_DATA1: begin
          state  <= (hit || last) ? S_DONE : S_ADDR0;
          ram_rd <= !(hit || last);
        end
        S_DONE:  state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // frame capture, index walk and ram address
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      xtd_q    <= 1'b0;
      id_q     <= 29'h0;
      idx_q    <= 7'h0;
      word0_q  <= 32'h0;
      ram_addr <= 16'h0;
    end else if (state == S_IDLE && frame.valid) begin
      xtd_q    <= frame.xtd;
      id_q     <= frame.xtd ? frame.id : {18'h0, frame.id[10:0]};
      idx_q    <= 7'h0;
      ram_addr <= frame.xtd ? ext_list_start_addr
                            : std_list_start_addr;
    end else if (state == S_DATA0 && xtd_q) begin
      word0_q  <= ram_rdata;
      ram_addr <= ram_addr + 16'h0001;
    end else if (eval && !hit && !last) begin
      idx_q    <= nidx;
      ram_addr <= xtd_q ? ext_ad : std_ad;
    end
  end

  // result and pulses toward receive handler and timestamp unit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_valid        <= 1'b0;
      result              <= '0;
      sync_rx             <= 1'b0;
      filter_event_pulses <= 3'h0;
    end else begin
      result_valid <= eval && (hit || last)
                   || (state == S_IDLE && frame.valid && fcnt == 8'h00);
      if (take) begin
        result <= '{matched: 1'b1, dest: dest, prio_match: prio,
                    ext: xtd_q, index: idx_q, buf_addr: buf_ad};
      end else if (state == S_IDLE && frame.valid) begin
        // cleared only when a new frame is taken, so the result stands
        result <= '{matched: 1'b0, dest: DEST_NONE, prio_match: 1'b0,
                    ext: frame.xtd, index: 7'h0, buf_addr: 16'h0};
      end
      // pulse even if the target fifo later refuses the frame
      sync_rx <= take && use_timestamp_unit && sbit;
      filter_event_pulses <= (take && cfg == 3'h7)
                           ? sel2[`CF_BUF_FE] : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software registers; a new priority match wins over the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      use_timestamp_unit       <= 1'b0;
      irq_enable               <= 1'b0;
      std_list_start_addr      <= 16'h0;
      std_count                <= 8'h0;
      ext_list_start_addr      <= 16'h0;
      ext_count                <= 8'h0;
      global_ext_id_mask       <= `CF_MASK_RESET;
      rx_buffer_start_addr     <= 16'h0;
      high_priority_match_flag <= 1'b0;
      priority_match_status    <= 10'h0;
      prio_irq                 <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        use_timestamp_unit <= reg_wdata[`CF_CTRL_STAMP];
        irq_enable         <= reg_wdata[`CF_CTRL_IRQEN];
      end
      if (wr_std) begin
        std_list_start_addr <= reg_wdata[15:0];
        std_count           <= reg_wdata[23:16];
      end
      if (wr_ext) begin
        ext_list_start_addr <= reg_wdata[15:0];
        ext_count           <= reg_wdata[23:16];
      end
      if (wr_mask) global_ext_id_mask <= reg_wdata[28:0];
      if (wr_rxb)  rx_buffer_start_addr <= reg_wdata[15:0];
      high_priority_match_flag <= pset
        || (high_priority_match_flag && !clr_pri);
      if (pset) begin
        priority_match_status <= {cfg == 3'h6, cfg != 3'h4,
                                  xtd_q, idx_q};
      end
      prio_irq <= irq_enable && (pset
        || (high_priority_match_flag && !clr_pri));
    end
  end

  // read mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `CF_REG_CTRL:     rd_mux = {30'h0, irq_enable, use_timestamp_unit};
      `CF_REG_STD_LIST: rd_mux = {8'h0, std_count, std_list_start_addr};
      `CF_REG_EXT_LIST: rd_mux = {8'h0, ext_count, ext_list_start_addr};
      `CF_REG_EXT_MASK: rd_mux = {3'h0, global_ext_id_mask};
      `CF_REG_RXBUF:    rd_mux = {16'h0, rx_buffer_start_addr};
      `CF_REG_PRIO_FLAG: rd_mux = {31'h0, high_priority_match_flag};
      `CF_REG_PRIO_STAT: rd_mux = {22'h0, priority_match_status};
      `CF_REG_RESULT:   rd_mux = {2'h0, busy, result};
      default:          rd_mux = 32'h0;
    endcase
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0;
      busy      <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
      busy      <= !(state == S_IDLE && !frame.valid)
                && !(state == S_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  a_sync_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    (take && use_timestamp_unit && sbit) |=> sync_rx)
    else $error("sync pulse missing after sync match");
  a_sync_cause: assert property (@(posedge ref_clk) disable iff (reset)
    sync_rx |-> $past(take) && $past(sbit) ##1 !sync_rx)
    else $error("sync pulse without cause or too long");
  a_fe_cause: assert property (@(posedge ref_clk) disable iff (reset)
    (filter_event_pulses != 3'h0) |-> $past(take && cfg == 3'h7)
    ##1 filter_event_pulses == 3'h0)
    else $error("filter event pulse wrong");
  a_stop_first: assert property (@(posedge ref_clk) disable iff (reset)
    take |=> result_valid && result.matched && state == S_DONE)
    else $error("search went on after a match");
  a_prio_set: assert property (@(posedge ref_clk) disable iff (reset)
    pset |=> high_priority_match_flag
    && priority_match_status[6:0] == $past(idx_q))
    else $error("priority match not recorded");
  a_std_off: assert property (@(posedge ref_clk) disable iff (reset)
    (state == S_DATA0 && !xtd_q && ram_rdata[`CF_TYPE] == 2'h3
     && ram_rdata[`CF_STD_CFG] != 3'h7) |=> !result.matched)
    else $error("disabled standard element matched");
  a_idx_step: assert property (@(posedge ref_clk) disable iff (reset)
    (eval && !hit && !last) |=> idx_q == $past(idx_q) + 7'h01
    && state == S_ADDR0)
    else $error("index did not step upward");
  a_buf_exact: assert property (@(posedge ref_clk) disable iff (reset)
    (take && cfg == 3'h7) |=> result.dest >= DEST_RXBUF
    && result.buf_addr == $past(buf_ad))
    else $error("buffer target wrong");
  a_prio_dest: assert property (@(posedge ref_clk) disable iff (reset)
    (take && cfg == 3'h4) |=> result.prio_match
    && result.dest == DEST_NONE)
    else $error("priority-only stored a frame");
  // an empty list answers at once with no match
  a_empty_list: assert property (@(posedge ref_clk) disable iff (reset)
    (state == S_IDLE && frame.valid && fcnt == 8'h00)
    |=> result_valid && !result.matched)
    else $error("empty list not answered");
  // the result stands untouched until a match or a new frame
  a_result_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (!take && !(state == S_IDLE && frame.valid)) |=> $stable(result))
    else $error("result changed without cause");
  // a reject element neither stores nor flags priority
  a_reject_dest: assert property (@(posedge ref_clk) disable iff (reset)
    (take && cfg == 3'h3) |=> result.dest == DEST_REJECT
    && !result.prio_match)
    else $error("reject element stored or flagged");
  // interrupt follows a priority match when enabled
  a_prio_irq: assert property (@(posedge ref_clk) disable iff (reset)
    (pset && irq_enable) |=> prio_irq)
    else $error("priority interrupt missing");

endmodule
`default_nettype wire

/* File: tb/ram_model.sv */
// message ram stand-in for the filter lists, one read port
// assumes the filter holds ram_addr while ram_rd is high
`timescale 1ns/1ps
`default_nettype none

module ram_model (
  input  wire logic        ref_clk,
  input  wire logic        ram_rd,
  input  wire logic [15:0] ram_addr,
  output logic      [31:0] ram_rdata
);
  logic [31:0] mem [0:511];

  //////////////////////////////////////////////////////////////////////////
  // word stands one cycle only; after that the port flips between the inverse and the word
  // every cycle, so a sample one cycle late by the filter cannot pass by luck
  always @(posedge ref_clk) begin
    if (ram_rd) begin
      ram_rdata <= mem[ram_addr[8:0]];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end

  initial ram_rdata = 32'h0;
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the receive acceptance filter
// assumes the ram model as filter list store and the filter's register map
`timescale 1ns/1ps
`default_nettype none

module testbench
  import can_filter_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  frame_t      frame;
  logic        busy;
  logic        ram_rd;
  logic [15:0] ram_addr;
  logic [31:0] ram_rdata;
  logic        result_valid;
  result_t     result;
  logic        sync_rx;
  logic [2:0]  filter_event_pulses;
  logic        prio_irq;
  logic [2:0]  fe_acc;
  logic [31:0] d;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          sync_cnt;
  int          rv_cnt;
  int          std_len;
  int          ext_len;

  can_rx_acceptance_filter dut (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame(frame), .busy(busy), .ram_rd(ram_rd),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .result_valid(result_valid), .result(result), .sync_rx(sync_rx),
    .filter_event_pulses(filter_event_pulses), .prio_irq(prio_irq)
  );

  ram_model ram (
    .ref_clk(ref_clk), .ram_rd(ram_rd), .ram_addr(ram_addr),
    .ram_rdata(ram_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // clock and pulse monitor; sync and result pulses are counted, event pulses only OR-ed together
  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (sync_rx === 1'b1) sync_cnt++;
    if (result_valid === 1'b1) rv_cnt++;
    fe_acc |= filter_event_pulses;
  end

  //////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  function automatic logic [31:0] se(input logic [1:0] t,
    input logic [2:0] c, input logic [10:0] a, input logic s,
    input logic [10:0] b);
    return {t, c, a, s, 4'h0, b};
  endfunction

  // one frame through the search; poke offers a second standard frame, id 1, while busy
  task automatic send(input logic x, input logic [28:0] id, input logic m,
    input dest_t dst, input logic p, input int idx, input int syn,
    input logic [2:0] fe, input logic [15:0] ba, input logic poke);
    int lat;
    int per;
    int n;
    int exp_lat;
    logic bz;
    // std elements take two cycles each, extended ones four
    per = x ? 4 : 2;
    n = x ? ext_len : std_len;
    exp_lat = m ? per * (idx + 1) : (n == 0 ? 0 : per * n);
    @(posedge ref_clk);
    #1;
    sync_cnt = 0;
    rv_cnt = 0;
    fe_acc = 3'h0;
    @(posedge ref_clk);
    frame <= '{1'b1, x, id};
    for (lat = 0; lat < 2000; lat++) begin
      @(posedge ref_clk);
      frame <= (poke && lat == 10) ? frame_t'{1'b1, 1'b0, 29'h1} : '0;
      #1;
      if (lat == 0) bz = busy;
      if (result_valid === 1'b1) break;
    end
    repeat (2) @(posedge ref_clk);
    #1;
    check("latency", exp_lat, lat);
    check("matched", m, result.matched);
    check("dest", dst, result.dest);
    check("priority", p, result[24]);
    if (m) check("index", idx, result.index);
    if (dst >= DEST_RXBUF) check("buf_addr", ba, result.buf_addr);
    check("sync pulses", syn, sync_cnt);
    check("event pulses", fe, fe_acc);
    check("result pulses", 1, rv_cnt);
    check("busy in search", 1'b1, bz);
    check("busy after", 1'b0, busy);
    check("ext", x, result.ext);
    check("prio_irq", p, prio_irq);
    if (p) begin
      reg_read(8'h18, d);
      check("prio status", {dst == DEST_FIFO1, dst != DEST_NONE, x,
        idx[6:0]}, d);
      reg_write(8'h14, 32'h1);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic reset_values();
    reg_write(8'h40, 32'hffffffff);
    reg_read(8'h0c, d);
    check("mask reset", 32'h1fffffff, d);
    reg_read(8'h40, d);
    check("unmapped read", 32'h0, d);
    reg_read(8'h14, d);
    check("prio flag", 32'h0, d);
    check("busy", 1'b0, busy);
  endtask

  task automatic std_scenario();
    ram.mem[0]  = se(2'h3, 3'h1, 11'h100, 1'b0, 11'h000);
    ram.mem[1]  = se(2'h1, 3'h0, 11'h100, 1'b0, 11'h100);
    ram.mem[2]  = se(2'h0, 3'h1, 11'h120, 1'b0, 11'h12f);
    ram.mem[3]  = se(2'h1, 3'h2, 11'h200, 1'b1, 11'h210);
    ram.mem[4]  = se(2'h2, 3'h3, 11'h300, 1'b0, 11'h7f0);
    ram.mem[5]  = se(2'h1, 3'h4, 11'h400, 1'b0, 11'h400);
    ram.mem[6]  = se(2'h1, 3'h5, 11'h500, 1'b1, 11'h500);
    ram.mem[7]  = se(2'h1, 3'h6, 11'h600, 1'b0, 11'h600);
    ram.mem[8]  = se(2'h0, 3'h7, 11'h700, 1'b0, 11'h145);
    ram.mem[9]  = se(2'h0, 3'h7, 11'h701, 1'b0, 11'h280);
    ram.mem[10] = se(2'h0, 3'h7, 11'h702, 1'b0, 11'h401);
    ram.mem[11] = se(2'h0, 3'h7, 11'h703, 1'b1, 11'h7c2);
    ram.mem[12] = se(2'h3, 3'h7, 11'h704, 1'b0, 11'h03f);
    std_len = 13;
    reg_write(8'h00, 32'h3);
    reg_write(8'h04, 32'h000d_0000);
    reg_write(8'h10, 32'h0000_0400);
    send(0, 29'h100, 0, DEST_NONE, 0, 0, 0, 3'h0, 16'h0, 0);
    send(0, 29'h12f, 1, DEST_FIFO0, 0, 2, 0, 3'h0, 16'h0, 0);
    send(0, 29'h130, 0, DEST_NONE, 0, 0, 0, 3'h0, 16'h0, 0);
    send(0, 29'h210, 1, DEST_FIFO1, 0, 3, 1, 3'h0, 16'h0, 0);
    send(0, 29'h30a, 1, DEST_REJECT, 0, 4, 0, 3'h0, 16'h0, 0);
    send(0, 29'h400, 1, DEST_NONE, 1, 5, 0, 3'h0, 16'h0, 0);
    send(0, 29'h500, 1, DEST_FIFO0, 1, 6, 1, 3'h0, 16'h0, 0);
    send(0, 29'h600, 1, DEST_FIFO1, 1, 7, 0, 3'h0, 16'h0, 0);
    send(0, 29'h700, 1, DEST_RXBUF, 0, 8, 0, 3'h5, 16'h0405, 0);
    send(0, 29'h701, 1, DEST_DBG_A, 0, 9, 0, 3'h2, 16'h0400, 0);
    send(0, 29'h702, 1, DEST_DBG_B, 0, 10, 0, 3'h0, 16'h0401, 0);
    send(0, 29'h703, 1, DEST_DBG_C, 0, 11, 1, 3'h7, 16'h0402, 0);
    send(0, 29'h704, 1, DEST_RXBUF, 0, 12, 0, 3'h0, 16'h043f, 0);
    send(0, 29'h708, 0, DEST_NONE, 0, 0, 0, 3'h0, 16'h0, 0);
    reg_write(8'h00, 32'h2);
    send(0, 29'h210, 1, DEST_FIFO1, 0, 3, 0, 3'h0, 16'h0, 0);
    reg_write(8'h00, 32'h3);
  endtask

  task automatic ext_scenario();
    ram.mem[384] = {3'h1, 29'h1000000};
    ram.mem[385] = {2'h3, 1'b0, 29'h1000fff};
    ram.mem[386] = {3'h2, 29'h0aaaaaa};
    ram.mem[387] = {2'h1, 1'b1, 29'h0bbbbbb};
    ram.mem[388] = {3'h7, 29'h1abcdef};
    ram.mem[389] = {2'h1, 1'b0, 29'h00004d1};
    ram.mem[390] = {3'h2, 29'h0000055};
    ram.mem[391] = {2'h2, 1'b0, 29'h00000ff};
    ext_len = 4;
    reg_write(8'h08, 32'h0004_0180);
    send(1, 29'h1000fff, 1, DEST_FIFO0, 0, 0, 0, 3'h0, 16'h0, 0);
    send(1, 29'h0bbbbbb, 1, DEST_FIFO1, 0, 1, 1, 3'h0, 16'h0, 0);
    send(1, 29'h1abcdef, 1, DEST_DBG_B, 0, 2, 0, 3'h3, 16'h0411, 0);
    send(1, 29'h00004d1, 0, DEST_NONE, 0, 0, 0, 3'h0, 16'h0, 0);
    send(1, 29'h1234555, 1, DEST_FIFO1, 0, 3, 0, 3'h0, 16'h0, 0);
    send(0, 29'h0000055, 0, DEST_NONE, 0, 0, 0, 3'h0, 16'h0, 0);
    reg_write(8'h0c, 32'h0000_0fff);
    send(1, 29'h1000800, 1, DEST_FIFO0, 0, 0, 0, 3'h0, 16'h0, 0);
    reg_write(8'h0c, 32'h1fff_ffff);
  endtask

  // full-length lists, a frame offered while busy, then an empty list
  task automatic long_lists();
    for (int i = 0; i < 128; i++) begin
      ram.mem[i] = se(2'h3, 3'h1, 11'h7ff, 1'b0, 11'h7ff);
    end
    for (int i = 0; i < 64; i++) begin
      ram.mem[384 + 2 * i] = {3'h0, 29'h123};
      ram.mem[385 + 2 * i] = {2'h1, 1'b0, 29'h123};
    end
    ram.mem[127] = se(2'h1, 3'h1, 11'h7ff, 1'b0, 11'h7ff);
    ram.mem[510] = {3'h1, 29'h123};
    std_len = 128;
    ext_len = 64;
    reg_write(8'h04, 32'h0080_0000);
    reg_write(8'h08, 32'h0040_0180);
    send(0, 29'h7ff, 1, DEST_FIFO0, 0, 127, 0, 3'h0, 16'h0, 1);
    send(1, 29'h123, 1, DEST_FIFO0, 0, 63, 0, 3'h0, 16'h0, 0);
    std_len = 0;
    reg_write(8'h04, 32'h0);
    send(0, 29'h7ff, 0, DEST_NONE, 0, 0, 0, 3'h0, 16'h0, 0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    reset = 1'b1;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame = '0;
    for (int i = 0; i < 512; i++) ram.mem[i] = 32'h0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    reset_values();
    std_scenario();
    ext_scenario();
    long_lists();
    final_report();
  end

  initial begin
    #300000;
    num_errors++;
    final_report();
  end
endmodule

`default_nettype wire
